// ==== capture_compare_unit.sv ====
// Sixteen-channel capture/compare unit with two reloadable time bases and an AXI4-Lite slave.
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "ccu_consts.svh"
module capture_compare_unit
    import ccu_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [`CCU_AW-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [`CCU_AW-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic gpt_overflow_i,
    input wire logic ext_count_i,
    input wire logic [`CCU_NPIN-1:0] pin_i,
    output logic [`CCU_NPIN-1:0] pin_o,
    output logic [`CCU_NPIN-1:0] pin_oe_o,
    output logic irq_o
);
    // Register state
    tb_ctrl_t ctrl, next_ctrl; // Time base control
    logic [`CCU_IRQ_W-1:0] irq_stat, next_irq_stat; // Sticky events
    logic [`CCU_IRQ_W-1:0] irq_mask, next_irq_mask; // Interrupt enables
    logic next_irq;
    logic [`CCU_TW-1:0] tmr [`CCU_NTB]; // Time base counters
    logic [`CCU_TW-1:0] next_tmr [`CCU_NTB];
    logic [`CCU_TW-1:0] rld [`CCU_NTB]; // Reload values
    logic [`CCU_TW-1:0] next_rld [`CCU_NTB];
    logic [`CCU_NTB-1:0] fresh, next_fresh; // Timer holds a value not yet compared
    logic [`CCU_NTB-1:0] tick; // Count enable this cycle
    logic [`CCU_NTB-1:0] tmr_ovf; // Wrap this cycle
    logic [2:0] phase, next_phase; // Staggered compare slot
    logic [`CCU_PW-1:0] pcnt, next_pcnt; // Prescaler
    // Synchronisers: stage one, stage two, and previous value for edges
    logic [2:0] ext_sync, next_ext_sync;
    logic [`CCU_NPIN-1:0] pin_s1, pin_s2, pin_prev;
    logic [`CCU_NPIN-1:0] next_pin_s1, next_pin_s2, next_pin_prev;
    // Channel state
    ch_cfg_t cfg [`CCU_NCH];
    logic [`CCU_TW-1:0] ch_val [`CCU_NCH];
    logic [`CCU_NCH-1:0] hit; // Event already given this period
    logic [`CCU_NCH-1:0] se_done; // Single event spent
    logic [`CCU_NCH-1:0] ch_evt, ch_tgl, ch_set, ch_clr, cap_edge;
    logic [`CCU_NDBL-1:0] dbl_tgl; // Toggles from partner registers
    logic [`CCU_NPIN-1:0] next_pin, next_oe;
    // Bus state
    logic aw_have, next_aw_have, w_have, next_w_have;
    logic [`CCU_AW-1:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    // Write commit decoded for the state groups
    logic wr_en;
    logic [1:0] wr_bank;
    logic [3:0] wr_idx;
    logic [31:0] wr_val, wr_lanes;
    logic [32:0] wr_look, rd_look; // Read views of the write and read addresses

    // Byte enables widened to a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] s);
        logic [31:0] m;
        m = 32'h0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{s[i]}};
        end
        return m;
    endfunction : lane_mask

    // Read view of a word; bit 32 flags an unmapped address
    function automatic logic [32:0] rd_word(input logic [`CCU_AW-1:0] a);
        logic [32:0] r;
        logic [3:0] i;
        r = {1'b0, 32'h0};
        i = a[`CCU_IDX_HI:`CCU_IDX_LO];
        unique case (a[`CCU_BANK_HI:`CCU_BANK_LO])
            `CCU_BANK_MISC: begin
                unique case (i)
                    `CCU_IDX_CTRL: r[$bits(tb_ctrl_t)-1:0] = ctrl;
                    `CCU_IDX_TMR_A: r[`CCU_TW-1:0] = tmr[0];
                    `CCU_IDX_RLD_A: r[`CCU_TW-1:0] = rld[0];
                    `CCU_IDX_TMR_B: r[`CCU_TW-1:0] = tmr[1];
                    `CCU_IDX_RLD_B: r[`CCU_TW-1:0] = rld[1];
                    `CCU_IDX_STAT: r[`CCU_IRQ_W-1:0] = irq_stat;
                    `CCU_IDX_MASK: r[`CCU_IRQ_W-1:0] = irq_mask;
                    `CCU_IDX_PINS: begin
                        r[`CCU_NPIN-1:0] = pin_o;
                        r[`CCU_PIN_IN_LSB +: `CCU_NPIN] = pin_s2;
                    end
                    default: r[32] = 1'b1; // Unmapped
                endcase
            end
            `CCU_BANK_CFG: r[$bits(ch_cfg_t)-1:0] = cfg[i];
            `CCU_BANK_VAL: r[`CCU_TW-1:0] = ch_val[i];
            default: r[32] = 1'b1; // Unmapped bank
        endcase
        return r;
    endfunction : rd_word

    // AXI4-Lite slave: address and data are caught in either order, then committed
    always_comb begin
        next_aw_have = aw_have;
        next_aw_addr = aw_addr;
        next_w_have = w_have;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid_o;
        next_bresp = s_axi_bresp_o;
        next_rvalid = s_axi_rvalid_o;
        next_rresp = s_axi_rresp_o;
        next_rdata = s_axi_rdata_o;
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            next_aw_have = 1'b1;
            next_aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            next_w_have = 1'b1;
            next_w_data = s_axi_wdata_i;
            next_w_strb = s_axi_wstrb_i;
        end
        // Commit once both halves are held and no answer is pending
        wr_en = aw_have && w_have && !s_axi_bvalid_o;
        wr_bank = aw_addr[`CCU_BANK_HI:`CCU_BANK_LO];
        wr_idx = aw_addr[`CCU_IDX_HI:`CCU_IDX_LO];
        wr_look = rd_word(aw_addr);
        rd_look = rd_word(s_axi_araddr_i);
        wr_lanes = w_data & lane_mask(w_strb);
        // Unselected byte lanes keep their present contents
        wr_val = (wr_look[31:0] & ~lane_mask(w_strb)) | wr_lanes;
        if (wr_en) begin
            next_aw_have = 1'b0;
            next_w_have = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_look[32] ? `CCU_RESP_ERR : `CCU_RESP_OK;
        end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            next_rvalid = 1'b1;
            next_rdata = rd_look[31:0];
            next_rresp = rd_look[32] ? `CCU_RESP_ERR : `CCU_RESP_OK;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            next_rvalid = 1'b0;
        end
        // Ready is refused while a word is held, so nothing is overwritten
        next_awready = !next_aw_have && !next_bvalid;
        next_wready = !next_w_have && !next_bvalid;
        next_arready = !next_rvalid;
    end

    // Bus registers
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            aw_have <= 1'b0;
            aw_addr <= '0;
            w_have <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `CCU_RESP_OK;
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rresp_o <= `CCU_RESP_OK;
            s_axi_rdata_o <= 32'h0;
        end else begin
            aw_have <= next_aw_have;
            aw_addr <= next_aw_addr;
            w_have <= next_w_have;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready_o <= next_awready;
            s_axi_wready_o <= next_wready;
            s_axi_bvalid_o <= next_bvalid;
            s_axi_bresp_o <= next_bresp;
            s_axi_arready_o <= next_arready;
            s_axi_rvalid_o <= next_rvalid;
            s_axi_rresp_o <= next_rresp;
            s_axi_rdata_o <= next_rdata;
        end
    end

    // Pin and count input synchronisers; edges look only at stage two onward
    always_comb begin
        next_ext_sync = {ext_sync[1:0], ext_count_i};
        next_pin_s1 = pin_i;
        next_pin_s2 = pin_s1;
        next_pin_prev = pin_s2;
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ext_sync <= 3'h0;
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_prev <= '0;
        end else begin
            ext_sync <= next_ext_sync;
            pin_s1 <= next_pin_s1;
            pin_s2 <= next_pin_s2;
            pin_prev <= next_pin_prev;
        end
    end

    // Time bases: prescaler, source select, count, reload and compare freshness
    always_comb begin
        logic [1:0] src;
        logic [2:0] presc;
        logic run;
        logic src_tick;
        logic [`CCU_PW-1:0] pmask;
        src = 2'h0;
        presc = 3'h0;
        run = 1'b0;
        src_tick = 1'b0;
        pmask = '0;
        next_ctrl = ctrl;
        next_pcnt = pcnt + `CCU_PW'(1);
        next_phase = phase + 3'h1;
        if (wr_en && wr_bank == `CCU_BANK_MISC && wr_idx == `CCU_IDX_CTRL) begin
            next_ctrl = tb_ctrl_t'(wr_val[$bits(tb_ctrl_t)-1:0]);
        end
        for (int t = 0; t < `CCU_NTB; t++) begin
            src = (t == 0) ? ctrl.src_a : ctrl.src_b;
            presc = (t == 0) ? ctrl.presc_a : ctrl.presc_b;
            run = (t == 0) ? ctrl.run_a : ctrl.run_b;
            pmask = `CCU_PW'((8'h01 << presc) - 8'h01);
            unique case (src)
                `CCU_SRC_PRESC: src_tick = (pcnt & pmask) == pmask;
                `CCU_SRC_GPT: src_tick = gpt_overflow_i;
                // Only the first time base has the external count input
                `CCU_SRC_PIN: src_tick = (t == 0) && ext_sync[1] && !ext_sync[2];
                default: src_tick = 1'b0;
            endcase
            // Staggered mode lets a timer move only at the end of the slot sweep;
            // a source pulse landing in another slot is not counted.
            tick[t] = run && src_tick && (!ctrl.staggered || phase == `CCU_STAG_LAST);
            tmr_ovf[t] = tick[t] && tmr[t] == `CCU_TMR_MAX;
            next_rld[t] = rld[t];
            next_tmr[t] = tmr[t];
            if (tick[t]) begin
                next_tmr[t] = tmr_ovf[t] ? rld[t] : tmr[t] + `CCU_TW'(1);
            end
            // A software load of the counter wins over counting
            if (wr_en && wr_bank == `CCU_BANK_MISC) begin
                if (wr_idx == ((t == 0) ? `CCU_IDX_TMR_A : `CCU_IDX_TMR_B)) begin
                    next_tmr[t] = wr_val[`CCU_TW-1:0];
                end
                if (wr_idx == ((t == 0) ? `CCU_IDX_RLD_A : `CCU_IDX_RLD_B)) begin
                    next_rld[t] = wr_val[`CCU_TW-1:0];
                end
            end
            // Each value is compared once: one cycle normally, one sweep staggered
            if (tick[t]) begin
                next_fresh[t] = 1'b1;
            end else if (ctrl.staggered) begin
                next_fresh[t] = fresh[t] && phase != `CCU_STAG_LAST;
            end else begin
                next_fresh[t] = 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl <= '0;
            pcnt <= '0;
            phase <= 3'h0;
            tmr <= '{default: '0};
            rld <= '{default: '0};
            fresh <= '0;
        end else begin
            ctrl <= next_ctrl;
            pcnt <= next_pcnt;
            phase <= next_phase;
            tmr <= next_tmr;
            rld <= next_rld;
            fresh <= next_fresh;
        end
    end

    // One slice per channel
    for (genvar n = 0; n < `CCU_NCH; n++) begin : g_ch
        ch_cfg_t next_cfg;
        logic [`CCU_TW-1:0] next_val;
        logic next_hit, next_se, match, active, tb;

        // Pin channels see synchronised edges of the selected kind
        if (n < `CCU_NPIN) begin : g_pin
            assign cap_edge[n] = (pin_s2[n] && !pin_prev[n] && cfg[n].edge_sel[0]) ||
                (!pin_s2[n] && pin_prev[n] && cfg[n].edge_sel[1]);
        end else begin : g_nopin
            assign cap_edge[n] = 1'b0;
        end
        // Upper channels may lend their toggles to a lower pin
        if (n >= `CCU_DBL_BASE) begin : g_dbl
            assign dbl_tgl[n-`CCU_DBL_BASE] = ch_tgl[n] && cfg[n].double_reg;
        end

        // Channel next state and its events
        always_comb begin
            tb = cfg[n].tb_sel;
            match = ch_val[n] == tmr[tb] && fresh[tb] &&
                (!ctrl.staggered || phase == 3'(n));
            active = !se_done[n];
            ch_evt[n] = 1'b0;
            ch_tgl[n] = 1'b0;
            ch_set[n] = 1'b0;
            ch_clr[n] = 1'b0;
            next_cfg = cfg[n];
            next_val = ch_val[n];
            next_hit = hit[n] && !tmr_ovf[tb];
            next_se = se_done[n];
            // A new configuration re-arms the channel
            if (wr_en && wr_bank == `CCU_BANK_CFG && wr_idx == 4'(n)) begin
                next_cfg = ch_cfg_t'(wr_val[$bits(ch_cfg_t)-1:0]);
                next_hit = 1'b0;
                next_se = 1'b0;
            end
            if (wr_en && wr_bank == `CCU_BANK_VAL && wr_idx == 4'(n)) begin
                next_val = wr_val[`CCU_TW-1:0];
            end
            unique case (cfg[n].mode)
                MODE_CAPTURE: begin
                    // A capture overrides a software write in the same cycle
                    if (cap_edge[n] && active) begin
                        next_val = tmr[tb];
                        ch_evt[n] = 1'b1;
                    end
                end
                MODE_CMP0: begin
                    ch_evt[n] = match && active;
                end
                MODE_CMP1: begin
                    ch_evt[n] = match && active;
                    ch_tgl[n] = match && active;
                end
                MODE_CMP2: begin
                    if (match && active && !hit[n]) begin
                        ch_evt[n] = 1'b1;
                        next_hit = 1'b1;
                    end
                end
                MODE_CMP3: begin
                    if (match && active && !hit[n]) begin
                        ch_evt[n] = 1'b1;
                        ch_set[n] = 1'b1;
                        next_hit = 1'b1;
                    end
                    // Clearing stays allowed so a single pulse can end
                    ch_clr[n] = tmr_ovf[tb];
                end
                default: begin
                    ch_evt[n] = 1'b0; // Off or unused code
                end
            endcase
            if (ch_evt[n] && cfg[n].single_event) begin
                next_se = 1'b1;
            end
        end

        always_ff @(posedge clock_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                cfg[n] <= '0;
                ch_val[n] <= '0;
                hit[n] <= 1'b0;
                se_done[n] <= 1'b0;
            end else begin
                cfg[n] <= next_cfg;
                ch_val[n] <= next_val;
                hit[n] <= next_hit;
                se_done[n] <= next_se;
            end
        end
    end

    // Pin drivers: set, clear, own toggle and partner toggle
    always_comb begin
        for (int p = 0; p < `CCU_NPIN; p++) begin
            next_pin[p] = pin_o[p];
            if (ch_set[p]) begin
                next_pin[p] = 1'b1;
            end
            if (ch_clr[p]) begin
                next_pin[p] = 1'b0;
            end
            next_pin[p] = next_pin[p] ^ ch_tgl[p];
            if (p < `CCU_NDBL) begin
                next_pin[p] = next_pin[p] ^ dbl_tgl[p];
            end
            // Pin is driven in the pin-changing compare modes; capture leaves it input
            next_oe[p] = cfg[p].mode == MODE_CMP1 || cfg[p].mode == MODE_CMP3;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_o <= '0;
            pin_oe_o <= '0;
        end else begin
            pin_o <= next_pin;
            pin_oe_o <= next_oe;
        end
    end

    // Interrupts: sticky status, write one to clear, a new event wins over the clear
    always_comb begin
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        if (wr_en && wr_bank == `CCU_BANK_MISC && wr_idx == `CCU_IDX_MASK) begin
            next_irq_mask = wr_val[`CCU_IRQ_W-1:0];
        end
        if (wr_en && wr_bank == `CCU_BANK_MISC && wr_idx == `CCU_IDX_STAT) begin
            next_irq_stat = irq_stat & ~wr_lanes[`CCU_IRQ_W-1:0];
        end
        next_irq_stat = next_irq_stat | {tmr_ovf, ch_evt};
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_stat <= '0;
            irq_mask <= '0;
            irq_o <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            irq_o <= next_irq;
        end
    end
endmodule : capture_compare_unit

// ==== ccu_consts.svh ====
// Constants for the capture/compare unit: sizes, map indexes, field codes.
`ifndef CCU_CONSTS_SVH
`define CCU_CONSTS_SVH
`define CCU_NCH 16
`define CCU_NPIN 10
`define CCU_NDBL 6
`define CCU_DBL_BASE 10
`define CCU_NTB 2
`define CCU_TW 16
`define CCU_AW 8
`define CCU_IRQ_W 18
`define CCU_BANK_HI 7
`define CCU_BANK_LO 6
`define CCU_IDX_HI 5
`define CCU_IDX_LO 2
`define CCU_BANK_MISC 2'h0
`define CCU_BANK_CFG 2'h1
`define CCU_BANK_VAL 2'h2
`define CCU_IDX_CTRL 4'h0
`define CCU_IDX_TMR_A 4'h1
`define CCU_IDX_RLD_A 4'h2
`define CCU_IDX_TMR_B 4'h3
`define CCU_IDX_RLD_B 4'h4
`define CCU_IDX_STAT 4'h5
`define CCU_IDX_MASK 4'h6
`define CCU_IDX_PINS 4'h7
`define CCU_PIN_IN_LSB 16
`define CCU_TMR_MAX 16'hffff
`define CCU_STAG_LAST 3'h7
`define CCU_PW 7
`define CCU_SRC_PRESC 2'h0
`define CCU_SRC_GPT 2'h1
`define CCU_SRC_PIN 2'h2
`define CCU_RESP_OK 2'h0
`define CCU_RESP_ERR 2'h2
`endif

// ==== ccu_pkg.sv ====
// Types for the capture/compare unit: channel modes and packed configuration words.
package ccu_pkg;
    // Channel operating mode, held in the channel configuration word
    typedef enum logic [2:0] {
        MODE_OFF = 3'h0,
        MODE_CAPTURE = 3'h1,
        MODE_CMP0 = 3'h2,
        MODE_CMP1 = 3'h3,
        MODE_CMP2 = 3'h4,
        MODE_CMP3 = 3'h5
    } ch_mode_t;
    // Channel configuration word, bit 0 upward: tb_sel, mode, edge_sel, single, double
    typedef struct packed {
        logic double_reg;
        logic single_event;
        logic [1:0] edge_sel;
        ch_mode_t mode;
        logic tb_sel;
    } ch_cfg_t;
    // Time base control word, bit 0 upward: run_a, src_a, presc_a, run_b, src_b, presc_b, staggered
    typedef struct packed {
        logic staggered;
        logic [2:0] presc_b;
        logic [1:0] src_b;
        logic run_b;
        logic [2:0] presc_a;
        logic [1:0] src_a;
        logic run_a;
    } tb_ctrl_t;
endpackage : ccu_pkg

// ==== ccu_checker.sv ====
// Port checks of the capture/compare unit bus handshakes.
`timescale 1ns/1ps
module ccu_checker (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic irq_o
);
    // One domain: clock and reset given once
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);
    aw_once_a: assert property (s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o)
        else $error("awready high after handshake");
    b_delay_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
        && s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("write response late");
    b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("bresp dropped");
    b_drop_a: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
        else $error("bvalid stuck");
    aw_block_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write taken during response");
    r_delay_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read response late");
    r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("rdata dropped");
    ar_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read taken during response");
    r_code_a: assert property (s_axi_rvalid_o |-> s_axi_rresp_o inside {2'h0, 2'h2})
        else $error("bad read response code");
    cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
    cover property ($rose(irq_o));
    cover property (s_axi_rvalid_o && s_axi_rready_i);
endmodule : ccu_checker

// ==== ccu_pin_model.sv ====
// Far-side pin model: capture levels in, unit-driven levels reflected.
`timescale 1ns/1ps
module ccu_pin_model (
    input wire logic [9:0] drive_i,
    input wire logic [9:0] pin_o_i,
    input wire logic [9:0] pin_oe_i,
    output logic [9:0] pin_level_o
);
    // Unit wins where it drives; else the far side sets the level
    always_comb begin
        pin_level_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & drive_i);
    end
endmodule : ccu_pin_model

// ==== dual_timebase_capture_compare_tb.sv ====
// Self-checking bench for the capture/compare unit.
`timescale 1ns/1ps
module dual_timebase_capture_compare_tb;
    typedef struct packed {logic [7:0] a; logic [31:0] d, e; logic [1:0] r;} row_t;
    logic clock_i = 0, sys_rst_i = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic gpt = 0, ext = 0, awr, wrd, bv, arr, rv, irq;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdt, v, t;
    logic [1:0] brs, rrs, r;
    logic [9:0] po, poe, pi, drv = 0;
    logic p;
    int failures = 0, compares = 0, hi;
    // Register rows: write, expected readback, expected response
    row_t rows [6] = '{'{8'h08, 32'hfff0, 32'hfff0, 2'h0}, '{8'h10, 32'habcd, 32'habcd, 2'h0},
        '{8'h18, 32'hffffffff, 32'h3ffff, 2'h0}, '{8'h4c, 32'hff, 32'hff, 2'h0},
        '{8'h8c, 32'h1234, 32'h1234, 2'h0}, '{8'h20, 32'h5, 32'h0, 2'h2}};
    logic [39:0] setup [11] = '{40'h04_0000fff0, 40'h80_0000fff8, 40'h40_00000006,
        40'h84_0000fff8, 40'h44_0000000a, 40'h90_0000fffa, 40'h50_00000008,
        40'h48_00000012, 40'h4c_00000022, 40'h18_0000001f, 40'h00_00000001};
    always #5 clock_i = ~clock_i;
    capture_compare_unit dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
        .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
        .s_axi_bresp_o(brs), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
        .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rdt), .s_axi_rresp_o(rrs), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
        .gpt_overflow_i(gpt), .ext_count_i(ext), .pin_i(pi), .pin_o(po), .pin_oe_o(poe),
        .irq_o(irq));
    ccu_pin_model pm (.drive_i(drv), .pin_o_i(po), .pin_oe_i(poe), .pin_level_o(pi));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(posedge clock_i);
    endtask : idle
    // Write: aw and w offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        tb = 0;
        @(posedge clock_i);
        awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
        while (!tb) begin
            @(negedge clock_i);
            ta = awv && awr; tw = wv && wrd; tb = bv; r = brs;
            @(posedge clock_i);
            if (ta) awv <= 0;
            if (tw) wv <= 0;
        end
        bry <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic ta, tv;
        tv = 0;
        @(posedge clock_i);
        ara <= a; arv <= 1; rry <= 1;
        while (!tv) begin
            @(negedge clock_i);
            ta = arv && arr; tv = rv; v = rdt; r = rrs;
            @(posedge clock_i);
            if (ta) arv <= 0;
        end
        rry <= 0;
    endtask : rd
    task automatic finish_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        idle(20000);
        failures++;
        finish_test();
    end
    initial begin
        idle(12);
        chk("oe_rst", poe, 0);
        chk("irq_rst", irq, 0);
        sys_rst_i <= 0;
        idle(2);
        rd(8'h14); chk("stat_rst", v, 0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d); chk("bresp", r, rows[i].r);
            rd(rows[i].a); chk("rdata", v, rows[i].e); chk("rresp", r, rows[i].r);
        end
        $display("register table done");
        foreach (setup[i]) wr(setup[i][39:32], setup[i][31:0]);
        idle(40);
        rd(8'h14); chk("stat_cmp", v, 32'h10013);
        chk("oe_cmp", poe, 10'h003);
        chk("irq_on", irq, 1);
        @(negedge clock_i) p = po[0];
        hi = 0;
        repeat (16) begin
            @(negedge clock_i);
            hi += po[1];
        end
        chk("toggle", po[0], {~p});
        chk("cmp3_high", hi >= 7 && hi <= 8, 1);
        wr(8'h00, 0); idle(4); wr(8'h14, 32'hffffffff);
        rd(8'h14); chk("w1c", v, 0);
        chk("irq_off", irq, 0);
        $display("compare test done");
        rd(8'h04); t = v;
        @(posedge clock_i) drv[2] <= 1;
        idle(8); rd(8'h88); chk("cap_val", v, t);
        rd(8'h14); chk("cap_rise", v, 32'h4);
        @(posedge clock_i) drv[3] <= 1;
        idle(8); rd(8'h14); chk("fall_only", v, 32'h4);
        @(posedge clock_i) drv[3] <= 0;
        idle(8); rd(8'h14); chk("cap_fall", v, 32'hc);
        chk("irq_cap", irq, 1);
        wr(8'h18, 0); rd(8'h14); chk("irq_mask", irq, 0);
        $display("capture test done");
        wr(8'h14, 32'hffffffff); wr(8'h18, 1); wr(8'h40, 32'h46); wr(8'h00, 1);
        idle(40); rd(8'h14); chk("single_1", v[0], 1);
        wr(8'h14, 1); idle(40); rd(8'h14); chk("single_2", v[0], 0);
        $display("single event test done");
        wr(8'h00, 0); wr(8'h04, 0); wr(8'h0c, 0); wr(8'h00, 32'hc5);
        repeat (5) begin
            @(posedge clock_i) ext <= 1;
            gpt <= 1;
            @(posedge clock_i) gpt <= 0;
            idle(3);
            ext <= 0;
            idle(4);
        end
        idle(6);
        rd(8'h04); chk("ext_cnt", v, 5);
        rd(8'h0c); chk("gpt_cnt", v, 5);
        $display("clock source test done");
        wr(8'h00, 0); wr(8'h04, 0); wr(8'h0c, 32'h100); wr(8'h54, 32'h5); wr(8'h94, 32'h102);
        wr(8'h68, 32'h86); wr(8'ha8, 2); wr(8'h14, 32'hffffffff); p = po[0];
        wr(8'h00, 32'h1041); idle(40); wr(8'h00, 0);
        rd(8'h04); chk("stagger", v > 4 && v < 7, 1);
        rd(8'h14); chk("cmp0_dbl", v, 32'h420);
        chk("dbl_pin", po[0], {~p});
        chk("cmp0_pin", poe[5], 0);
        $display("staggered test done");
        finish_test();
    end
endmodule : dual_timebase_capture_compare_tb
bind capture_compare_unit ccu_checker chk_u (.clock_i, .sys_rst_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .irq_o);
